// ### design/list_seq_pkg.sv
// Shared constants and types for the list sequencer and digital port.
`default_nettype none

package list_seq_pkg;

	// ------------------------------------------------------------------
	// Port geometry
	// ------------------------------------------------------------------
	localparam int unsigned PIN_N = 7;
	localparam int unsigned PIN_SEL_W = 3;
	localparam int unsigned PIN_FAULT = 0;
	localparam int unsigned PIN_COMMON = 1;
	localparam int unsigned PIN_INHIBIT = 2;
	localparam int unsigned CHAN_N = 4;

	// ------------------------------------------------------------------
	// List storage
	// ------------------------------------------------------------------
	localparam int unsigned LIST_DEPTH = 512;
	localparam int unsigned IDX_W = 9;
	localparam int unsigned CNT_W = 10;
	localparam logic [CNT_W-1:0] CNT_RST = 10'h001;
	localparam int unsigned LEVEL_W = 16;
	localparam logic [LEVEL_W-1:0] LEVEL_MIN = 16'h0000;
	localparam int unsigned DWELL_W = 18;
	localparam int unsigned RANGE_W = 2;
	// Dwell after reset is 0.001 s, held as 1000 units of 1 us.
	localparam logic [DWELL_W-1:0] DWELL_RST = 18'h0_03E8;
	localparam logic [RANGE_W-1:0] RANGE_RST = 2'h0;

	// ------------------------------------------------------------------
	// Repetition count
	// ------------------------------------------------------------------
	localparam int unsigned REP_W = 9;
	localparam logic [REP_W-1:0] REP_MIN = 9'h001;
	localparam logic [REP_W-1:0] REP_MAX = 9'h100;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned US_NS = 1000;
	localparam int unsigned CYC_PER_US_DFLT = US_NS / CLK_PERIOD_NS;
	localparam int unsigned DECADE = 10;
	localparam int unsigned UNIT_W = 24;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		general_io_pin = 3'h0,
		input_only_pin = 3'h1,
		trigger_out_pin = 3'h2,
		trigger_in_pin = 3'h3,
		fault_out_pin = 3'h4,
		inhibit_in_pin = 3'h5
	} pin_func_t;

	typedef enum logic {
		active_high = 1'h0,
		active_low = 1'h1
	} pin_pol_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ARMED = 3'h1,
		S_LOAD = 3'h2,
		S_DWELL = 3'h3,
		S_WAIT = 3'h4
	} seq_state_t;

endpackage

`default_nettype wire

// ### design/dwell_timer.sv
// Dwell timer: counts a step's dwell in decade-scaled time units.
`default_nettype none

module dwell_timer #(
	parameter int unsigned CYC_PER_US = list_seq_pkg::CYC_PER_US_DFLT
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Dwell request
	input wire logic start_i,
	input wire logic [list_seq_pkg::DWELL_W-1:0] mant_i,
	input wire logic [list_seq_pkg::RANGE_W-1:0] range_i,
	// Dwell over
	output logic done_o
);
	import list_seq_pkg::*;

	localparam logic [UNIT_W-1:0] U0 = UNIT_W'(CYC_PER_US);
	localparam logic [UNIT_W-1:0] U1 = UNIT_W'(CYC_PER_US * DECADE);
	localparam logic [UNIT_W-1:0] U2 = UNIT_W'(CYC_PER_US * DECADE * DECADE);
	localparam logic [UNIT_W-1:0] U3 =
		UNIT_W'(CYC_PER_US * DECADE * DECADE * DECADE);

	logic busy_q;
	logic [DWELL_W-1:0] rem_q;
	logic [UNIT_W-1:0] unit_cnt_q;
	logic [UNIT_W-1:0] len_q;
	logic [UNIT_W-1:0] unit_len;
	wire unit_end = (unit_cnt_q == len_q - UNIT_W'(1));

	// ------------------------------------------------------------------
	// Resolution select: 1 us, 10 us, 100 us or 1 ms per unit
	// ------------------------------------------------------------------
	always_comb
	begin
		case (range_i)
			2'h0: unit_len = U0;
			2'h1: unit_len = U1;
			2'h2: unit_len = U2;
			default: unit_len = U3;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			busy_q <= 1'b0;
			rem_q <= '0;
			unit_cnt_q <= '0;
			len_q <= U0;
		end
		else if (start_i)
		begin
			busy_q <= 1'b1;
			rem_q <= mant_i;
			unit_cnt_q <= '0;
			len_q <= unit_len;
		end
		else if (busy_q)
		begin
			if (rem_q == '0)
				busy_q <= 1'b0;
			else if (unit_end)
			begin
				unit_cnt_q <= '0;
				rem_q <= rem_q - DWELL_W'(1);
			end
			else
				unit_cnt_q <= unit_cnt_q + UNIT_W'(1);
		end
	end

	// A zero dwell ends one cycle after the start.
	assign done_o = busy_q && (rem_q == '0);

endmodule

`default_nettype wire

// ### design/list_sequencer_digital_port.sv
// List sequencer with the seven-pin digital control port.
`default_nettype none

module list_sequencer_digital_port #(
	parameter int unsigned CYC_PER_US = list_seq_pkg::CYC_PER_US_DFLT
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Digital port pins
	input wire logic [list_seq_pkg::PIN_N-1:0] pad_i,
	output logic [list_seq_pkg::PIN_N-1:0] pad_o,
	output logic [list_seq_pkg::PIN_N-1:0] pad_oe_o,
	// Port data
	input wire logic out_wr_i,
	input wire logic [list_seq_pkg::PIN_N-1:0] out_data_i,
	output logic [list_seq_pkg::PIN_N-1:0] out_data_o,
	output logic [list_seq_pkg::PIN_N-1:0] in_data_o,
	// Pin configuration
	input wire logic pin_wr_i,
	input wire logic [list_seq_pkg::PIN_SEL_W-1:0] pin_sel_i,
	input wire list_seq_pkg::pin_func_t pin_func_i,
	input wire list_seq_pkg::pin_pol_t pin_pol_i,
	input wire logic nv_load_i,
	input wire list_seq_pkg::pin_func_t nv_func_i [list_seq_pkg::PIN_N],
	input wire logic [list_seq_pkg::PIN_N-1:0] nv_pol_i,
	output list_seq_pkg::pin_func_t func_o [list_seq_pkg::PIN_N],
	output logic [list_seq_pkg::PIN_N-1:0] pol_o,
	// Protection
	input wire logic [list_seq_pkg::CHAN_N-1:0] protect_i,
	output logic outputs_inhibit_o,
	// Triggers
	input wire logic sw_trig_i,
	input wire logic trans_src_pin_i,
	input wire logic meas_src_pin_i,
	output logic meas_trig_o,
	// List programming
	input wire logic list_clear_i,
	input wire logic level_wr_i,
	input wire logic [list_seq_pkg::LEVEL_W-1:0] level_data_i,
	input wire logic dwell_wr_i,
	input wire logic [list_seq_pkg::DWELL_W-1:0] dwell_mant_i,
	input wire logic [list_seq_pkg::RANGE_W-1:0] dwell_range_i,
	input wire logic bos_wr_i,
	input wire logic bos_data_i,
	input wire logic eos_wr_i,
	input wire logic eos_data_i,
	output logic [list_seq_pkg::CNT_W-1:0] level_points_o,
	output logic [list_seq_pkg::CNT_W-1:0] dwell_points_o,
	// Sequencer control
	input wire logic cfg_wr_i,
	input wire logic [list_seq_pkg::REP_W-1:0] cfg_count_i,
	input wire logic cfg_endless_i,
	input wire logic cfg_single_i,
	input wire logic cfg_hold_final_i,
	input wire logic cfg_trig_out_i,
	input wire logic imm_wr_i,
	input wire logic [list_seq_pkg::LEVEL_W-1:0] imm_data_i,
	input wire logic initiate_i,
	input wire logic abort_i,
	// Sequencer status
	output logic [list_seq_pkg::LEVEL_W-1:0] level_o,
	output logic [list_seq_pkg::IDX_W-1:0] step_o,
	output logic list_active_o
);
	import list_seq_pkg::*;

	localparam logic [PIN_SEL_W-1:0] SEL_N = PIN_SEL_W'(PIN_N);
	localparam logic [PIN_SEL_W-1:0] SEL_FAULT = PIN_SEL_W'(PIN_FAULT);
	localparam logic [PIN_SEL_W-1:0] SEL_COMMON = PIN_SEL_W'(PIN_COMMON);
	localparam logic [PIN_SEL_W-1:0] SEL_INH = PIN_SEL_W'(PIN_INHIBIT);
	localparam logic [CNT_W-1:0] CNT_DEPTH = CNT_W'(LIST_DEPTH);

	// ------------------------------------------------------------------
	// Pin configuration
	// ------------------------------------------------------------------
	pin_func_t func_q [PIN_N];
	pin_func_t func_d [PIN_N];
	logic [PIN_N-1:0] pol_q;
	logic [PIN_N-1:0] pol_d;
	logic [PIN_N-1:0] out_q;
	logic [PIN_N-1:0] in_q;

	wire fault_on = (func_q[PIN_FAULT] == fault_out_pin);
	wire sel_ok = (pin_sel_i < SEL_N);
	wire sel_locked = fault_on && (pin_sel_i == SEL_COMMON);
	wire func_legal = !((pin_func_i == fault_out_pin) &&
		(pin_sel_i != SEL_FAULT)) &&
		!((pin_func_i == inhibit_in_pin) && (pin_sel_i != SEL_INH));
	wire cfg_take = pin_wr_i && sel_ok && !sel_locked;

	always_comb
	begin
		func_d = func_q;
		pol_d = pol_q;
		if (nv_load_i)
		begin
			func_d = nv_func_i;
			pol_d = nv_pol_i;
		end
		else if (cfg_take)
		begin
			if (func_legal)
				func_d[pin_sel_i] = pin_func_i;
			pol_d[pin_sel_i] = pin_pol_i;
		end
		if (fault_on && (func_d[PIN_FAULT] != fault_out_pin))
			func_d[PIN_COMMON] = input_only_pin;
	end

	// Reset gives a known default; the stored image is restored by nv_load.
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			func_q <= '{default: general_io_pin};
			pol_q <= '0;
		end
		else
		begin
			func_q <= func_d;
			pol_q <= pol_d;
		end
	end

	always_comb
	begin
		func_o = func_q;
		if (fault_on)
			func_o[PIN_COMMON] = fault_out_pin;
	end
	assign pol_o = pol_q;

	// ------------------------------------------------------------------
	// Port data, triggers, fault and inhibit
	// ------------------------------------------------------------------
	logic [PIN_N-1:0] true_prev_q;
	logic [PIN_N-1:0] is_tin;
	logic [PIN_N-1:0] drv_oe;
	logic [PIN_N-1:0] drv_lvl;
	logic inhibit_q;
	logic fault_q;
	logic trig_pulse;

	wire [PIN_N-1:0] pin_true = pad_i ^ pol_q;
	wire pin_trig = |(pin_true & ~true_prev_q & is_tin);
	wire trans_trig = trans_src_pin_i ? pin_trig : sw_trig_i;
	wire inhibit_now = (func_q[PIN_INHIBIT] == inhibit_in_pin) &&
		pin_true[PIN_INHIBIT];

	always_comb
	begin
		for (int i = 0; i < PIN_N; i++)
		begin
			is_tin[i] = (func_o[i] == trigger_in_pin);
			case (func_o[i])
				general_io_pin:
				begin
					drv_oe[i] = 1'b1;
					drv_lvl[i] = out_q[i] ^ pol_q[i];
				end
				trigger_out_pin:
				begin
					drv_oe[i] = 1'b1;
					drv_lvl[i] = trig_pulse ^ pol_q[i];
				end
				fault_out_pin:
				begin
					// Pin two is only the fault pin's common.
					drv_oe[i] = (i == PIN_FAULT);
					drv_lvl[i] = (fault_q ^ pol_q[i]) && (i == PIN_FAULT);
				end
				default:
				begin
					drv_oe[i] = 1'b0;
					drv_lvl[i] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			out_q <= '0;
			in_q <= '0;
			true_prev_q <= '0;
			pad_o <= '0;
			pad_oe_o <= '0;
			inhibit_q <= 1'b0;
			fault_q <= 1'b0;
			meas_trig_o <= 1'b0;
		end
		else
		begin
			if (out_wr_i)
				out_q <= out_data_i;
			in_q <= pad_i;
			true_prev_q <= pin_true;
			pad_o <= drv_lvl;
			pad_oe_o <= drv_oe;
			inhibit_q <= inhibit_now;
			fault_q <= (|protect_i) || inhibit_now;
			meas_trig_o <= meas_src_pin_i && pin_trig;
		end
	end

	assign out_data_o = out_q;
	assign in_data_o = in_q;
	assign outputs_inhibit_o = inhibit_q;

	// ------------------------------------------------------------------
	// List memories, appended in write order
	// ------------------------------------------------------------------
	logic [LEVEL_W-1:0] level_mem [LIST_DEPTH];
	logic [DWELL_W+RANGE_W-1:0] dwell_mem [LIST_DEPTH];
	logic bos_mem [LIST_DEPTH];
	logic eos_mem [LIST_DEPTH];
	logic [CNT_W-1:0] lvl_cnt_q, dw_cnt_q, bos_cnt_q, eos_cnt_q;
	logic init_q;

	function automatic logic [CNT_W-1:0] cnt_next(
		input logic [CNT_W-1:0] cnt, input logic wr);
		cnt_next = (wr && (cnt < CNT_DEPTH)) ? cnt + CNT_W'(1) : cnt;
	endfunction

	// Entry zero is rewritten to its defaults in the cycle after reset.
	always_ff @(posedge ref_clk_i)
	begin
		if (init_q)
		begin
			level_mem[0] <= LEVEL_MIN;
			dwell_mem[0] <= {RANGE_RST, DWELL_RST};
			bos_mem[0] <= 1'b0;
			eos_mem[0] <= 1'b0;
		end
		else
		begin
			if (level_wr_i && lvl_cnt_q < CNT_DEPTH)
				level_mem[lvl_cnt_q[IDX_W-1:0]] <= level_data_i;
			if (dwell_wr_i && dw_cnt_q < CNT_DEPTH)
				dwell_mem[dw_cnt_q[IDX_W-1:0]] <= {dwell_range_i, dwell_mant_i};
			if (bos_wr_i && bos_cnt_q < CNT_DEPTH)
				bos_mem[bos_cnt_q[IDX_W-1:0]] <= bos_data_i;
			if (eos_wr_i && eos_cnt_q < CNT_DEPTH)
				eos_mem[eos_cnt_q[IDX_W-1:0]] <= eos_data_i;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			init_q <= 1'b1;
			lvl_cnt_q <= CNT_RST;
			dw_cnt_q <= CNT_RST;
			bos_cnt_q <= CNT_RST;
			eos_cnt_q <= CNT_RST;
		end
		else if (list_clear_i)
		begin
			init_q <= 1'b0;
			lvl_cnt_q <= '0;
			dw_cnt_q <= '0;
			bos_cnt_q <= '0;
			eos_cnt_q <= '0;
		end
		else
		begin
			init_q <= 1'b0;
			lvl_cnt_q <= init_q ? lvl_cnt_q : cnt_next(lvl_cnt_q, level_wr_i);
			dw_cnt_q <= init_q ? dw_cnt_q : cnt_next(dw_cnt_q, dwell_wr_i);
			bos_cnt_q <= init_q ? bos_cnt_q : cnt_next(bos_cnt_q, bos_wr_i);
			eos_cnt_q <= init_q ? eos_cnt_q : cnt_next(eos_cnt_q, eos_wr_i);
		end
	end

	assign level_points_o = lvl_cnt_q;
	assign dwell_points_o = dw_cnt_q;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	seq_state_t st_q, st_d;
	logic [IDX_W-1:0] idx_q, idx_d;
	logic [REP_W-1:0] rep_q, rep_left_q, rep_left_d;
	logic endless_q, single_q, hold_q, tout_q;
	logic [LEVEL_W-1:0] imm_q, level_q;
	logic dwell_done, finish;

	// A one-entry dwell or flag list applies to every step.
	wire [CNT_W-1:0] idx_w = CNT_W'(idx_q);
	wire [IDX_W-1:0] dw_idx = (dw_cnt_q == CNT_RST) ? '0 : idx_q;
	wire [DWELL_W+RANGE_W-1:0] dw_word = dwell_mem[dw_idx];
	wire bos_flag = (bos_cnt_q == CNT_RST) ? bos_mem[0] :
		((idx_w < bos_cnt_q) && bos_mem[idx_q]);
	wire eos_flag = (eos_cnt_q == CNT_RST) ? eos_mem[0] :
		((idx_w < eos_cnt_q) && eos_mem[idx_q]);
	wire last_step = (idx_w == lvl_cnt_q - CNT_W'(1));
	wire more_reps = endless_q || (rep_left_q > REP_MIN);
	wire [REP_W-1:0] cnt_clamped = (cfg_count_i < REP_MIN) ? REP_MIN :
		((cfg_count_i > REP_MAX) ? REP_MAX : cfg_count_i);

	dwell_timer #(
		.CYC_PER_US(CYC_PER_US)
	) u_dwell (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.start_i(st_q == S_LOAD),
		.mant_i(dw_word[DWELL_W-1:0]),
		.range_i(dw_word[DWELL_W+RANGE_W-1:DWELL_W]),
		.done_o(dwell_done)
	);

	always_comb
	begin
		st_d = st_q;
		idx_d = idx_q;
		rep_left_d = rep_left_q;
		finish = 1'b0;
		trig_pulse = 1'b0;
		case (st_q)
			S_IDLE:
				if (initiate_i && (lvl_cnt_q != '0))
				begin
					st_d = S_ARMED;
					idx_d = '0;
					rep_left_d = rep_q;
				end
			S_ARMED:
				if (trans_trig)
					st_d = S_LOAD;
			S_LOAD:
			begin
				trig_pulse = tout_q && bos_flag;
				st_d = S_DWELL;
			end
			S_DWELL:
				// Triggers are not looked at while the dwell runs.
				if (dwell_done)
				begin
					trig_pulse = tout_q && eos_flag;
					st_d = single_q ? S_WAIT : S_LOAD;
					if (!last_step)
						idx_d = idx_q + IDX_W'(1);
					else if (more_reps)
					begin
						idx_d = '0;
						if (!endless_q)
							rep_left_d = rep_left_q - REP_W'(1);
					end
					else
					begin
						st_d = S_IDLE;
						finish = 1'b1;
					end
				end
			S_WAIT:
				if (trans_trig)
					st_d = S_LOAD;
			default:
				st_d = S_IDLE;
		endcase
		if (abort_i)
		begin
			st_d = S_IDLE;
			finish = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			st_q <= S_IDLE;
			idx_q <= '0;
			rep_q <= REP_MIN;
			rep_left_q <= REP_MIN;
			endless_q <= 1'b0;
			single_q <= 1'b0;
			hold_q <= 1'b0;
			tout_q <= 1'b0;
			imm_q <= LEVEL_MIN;
		end
		else
		begin
			st_q <= st_d;
			idx_q <= idx_d;
			rep_left_q <= rep_left_d;
			if (cfg_wr_i)
			begin
				rep_q <= cnt_clamped;
				endless_q <= cfg_endless_i;
				single_q <= cfg_single_i;
				hold_q <= cfg_hold_final_i;
				tout_q <= cfg_trig_out_i;
			end
			if (finish && hold_q)
				imm_q <= level_q;
			else if (imm_wr_i)
				imm_q <= imm_data_i;
		end
	end

	// Outside a run the output shows the immediate setting.
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
			level_q <= LEVEL_MIN;
		else if (st_q == S_LOAD)
			level_q <= level_mem[idx_q];
		else if ((st_q == S_IDLE) || (st_q == S_ARMED))
			level_q <= imm_q;
	end

	assign level_o = level_q;
	assign step_o = idx_q;
	assign list_active_o = (st_q != S_IDLE);

endmodule

`default_nettype wire

// ### testbench/list_seq_sva.sv
// Port-level assertions for the list sequencer and digital port.
`default_nettype none

module list_seq_sva (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Pins and port data
	input wire logic [6:0] pad_i,
	input wire logic [6:0] pad_o,
	input wire logic [6:0] pad_oe_o,
	input wire logic out_wr_i,
	input wire logic [6:0] out_data_i,
	input wire logic [6:0] out_data_o,
	input wire logic [6:0] in_data_o,
	// Configuration and protection
	input wire list_seq_pkg::pin_func_t func_o [list_seq_pkg::PIN_N],
	input wire logic [6:0] pol_o,
	input wire logic [3:0] protect_i,
	input wire logic outputs_inhibit_o,
	// Sequencer
	input wire logic abort_i,
	input wire logic list_clear_i,
	input wire logic level_wr_i,
	input wire logic [9:0] level_points_o,
	input wire logic list_active_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import list_seq_pkg::*;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	a_word_readback: assert property (
		out_wr_i |=> out_data_o == $past(out_data_i))
		else $error("output word readback differs");
	a_input_live: assert property (
		$past(resetn_i) |-> in_data_o == $past(pad_i))
		else $error("input word is not the pin levels");
	a_gpio_drive: assert property (
		(func_o[3] == general_io_pin && $stable(pol_o[3]))[*3] |->
		pad_oe_o[3] && pad_o[3] == ($past(out_data_o[3]) ^ pol_o[3]))
		else $error("general pin does not follow the word");
	a_input_undriven: assert property (
		(func_o[4] == input_only_pin)[*2] |-> !pad_oe_o[4])
		else $error("input-only pin is driven");
	a_fault_lock: assert property (
		func_o[0] == fault_out_pin |-> func_o[1] == fault_out_pin)
		else $error("common pin does not read as fault");
	a_fault_leave: assert property (
		$past(func_o[0]) == fault_out_pin && func_o[0] != fault_out_pin
		|-> func_o[1] == input_only_pin)
		else $error("common pin not input-only after fault");
	a_fault_output: assert property (
		(func_o[0] == fault_out_pin && !pol_o[0] && !outputs_inhibit_o)[*3]
		|-> pad_oe_o[0] && pad_o[0] == ($past(protect_i, 2) != 4'h0))
		else $error("fault output does not track protection");
	a_inhibit_follow: assert property (
		(func_o[2] == inhibit_in_pin && $stable(pol_o[2]))[*2] |->
		outputs_inhibit_o == ($past(pad_i[2]) ^ pol_o[2]))
		else $error("inhibit does not follow its pin");
	a_abort_stops: assert property (
		abort_i |=> !list_active_o)
		else $error("list still active after abort");
	a_level_append: assert property (
		level_wr_i && !list_clear_i && $past(resetn_i) &&
		level_points_o < 10'h200 |=>
		level_points_o == $past(level_points_o) + 10'h001)
		else $error("level point count did not advance");
	a_trig_quiet: assert property (
		(func_o[5] == trigger_out_pin && !pol_o[5] && !list_active_o)[*3]
		|-> !pad_o[5])
		else $error("trigger output pulsed while idle");

	c_list_end: cover property (list_active_o ##1 !list_active_o);
	c_fault_on: cover property (func_o[0] == fault_out_pin && pad_o[0]);
	c_inhibit: cover property (outputs_inhibit_o);
endmodule

`default_nettype wire

// ### testbench/ext_equipment.sv
// External equipment on the digital port, with wire resolution.
`default_nettype none

module ext_equipment (
	// Clock
	input wire logic ref_clk_i,
	// Device drive
	input wire logic [6:0] pad_o,
	input wire logic [6:0] pad_oe_o,
	// Far-side drive
	input wire logic [6:0] ext_val_i,
	input wire logic [6:0] ext_en_i,
	// Resolved wire level
	output logic [6:0] pad_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] last_q = '0;
	// A floating line shows the inverse of its last level, so a stale
	// value can never pass for a driven one.
	// An enable not yet set by reset counts as released, so no unknown
	// level is ever latched and carried forward.
	always_comb
		for (int i = 0; i < 7; i++)
			pad_i[i] = (pad_oe_o[i] === 1'b1) ? pad_o[i] :
				(ext_en_i[i] ? ext_val_i[i] : ~last_q[i]);
	always_ff @(posedge ref_clk_i)
		last_q <= pad_i;
endmodule

`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the list sequencer and digital port.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import list_seq_pkg::*;
	logic ref_clk_i = 0, resetn_i = 0, out_wr_i = 0, pin_wr_i = 0;
	logic nv_load_i = 0, sw_trig_i = 0, trans_src_pin_i = 0;
	logic meas_src_pin_i = 0, list_clear_i = 0, level_wr_i = 0;
	logic dwell_wr_i = 0, bos_wr_i = 0, bos_data_i = 0, eos_wr_i = 0;
	logic eos_data_i = 0, cfg_wr_i = 0, cfg_endless_i = 0;
	logic cfg_single_i = 0, cfg_hold_final_i = 0, cfg_trig_out_i = 0;
	logic imm_wr_i = 0, initiate_i = 0, abort_i = 0;
	logic outputs_inhibit_o, meas_trig_o, list_active_o;
	logic [6:0] pad_i, pad_o, pad_oe_o, out_data_o, in_data_o, pol_o;
	logic [6:0] out_data_i = 0, nv_pol_i = 0, ext_val = 0, ext_en = 0;
	logic [6:0] w, v, e;
	logic [2:0] pin_sel_i = 0;
	pin_func_t pin_func_i = general_io_pin, func_o [7];
	pin_func_t nv_func_i [7] = '{default: input_only_pin};
	pin_func_t ft [7] = '{general_io_pin, general_io_pin, general_io_pin,
		general_io_pin, input_only_pin, trigger_out_pin, trigger_in_pin};
	pin_pol_t pin_pol_i = active_high;
	logic [3:0] protect_i = 0;
	logic [15:0] level_data_i = 0, imm_data_i = 16'hC3C3, level_o;
	logic [15:0] lv [$], ex [$], lvl [3];
	logic [17:0] dwell_mant_i = 0;
	logic [1:0] dwell_range_i = 0;
	logic [9:0] level_points_o, dwell_points_o;
	logic [8:0] cfg_count_i = 1, step_o;
	logic [31:0] seed = 4774, r;
	int mismatches = 0, compares = 0, pulses, span;

	list_sequencer_digital_port #(.CYC_PER_US(1))
		list_sequencer_digital_port_i (.*);
	ext_equipment ext_equipment_i (.ref_clk_i, .pad_o, .pad_oe_o,
		.ext_val_i(ext_val), .ext_en_i(ext_en), .pad_i);

	always #25 ref_clk_i = ~ref_clk_i;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic set_pin(int s, pin_func_t f, pin_pol_t p);
		@(posedge ref_clk_i);
		pin_wr_i <= 1;
		pin_sel_i <= 3'(s);
		pin_func_i <= f;
		pin_pol_i <= p;
		@(posedge ref_clk_i);
		pin_wr_i <= 0;
	endtask
	// Strobes: 0 initiate, 1 software trigger, 2 abort, 3 clear, 4 immediate level.
	task automatic kick(int k);
		@(posedge ref_clk_i);
		{imm_wr_i, list_clear_i, abort_i, sw_trig_i, initiate_i} <= 5'(1 << k);
		@(posedge ref_clk_i);
		{imm_wr_i, list_clear_i, abort_i, sw_trig_i, initiate_i} <= 5'h00;
	endtask
	task automatic add_step(logic [15:0] l, logic [17:0] d, logic [1:0] g,
		logic b, logic f);
		@(posedge ref_clk_i);
		{level_wr_i, dwell_wr_i, bos_wr_i, eos_wr_i} <= 4'hF;
		{level_data_i, dwell_mant_i, dwell_range_i} <= {l, d, g};
		{bos_data_i, eos_data_i} <= {b, f};
		@(posedge ref_clk_i);
		{level_wr_i, dwell_wr_i, bos_wr_i, eos_wr_i} <= 4'h0;
	endtask
	task automatic set_cfg(int n, logic en, logic s, logic h, logic t);
		@(posedge ref_clk_i);
		cfg_wr_i <= 1;
		cfg_count_i <= 9'(n);
		cfg_endless_i <= en;
		{cfg_single_i, cfg_hold_final_i, cfg_trig_out_i} <= {s, h, t};
		@(posedge ref_clk_i);
		cfg_wr_i <= 0;
	endtask
	// Records each new output level and counts trigger-out pulses.
	task automatic watch(int lim);
		logic prev;
		prev = 0;
		lv = {};
		pulses = 0;
		for (span = 0; span < lim && list_active_o; span++)
		begin
			@(negedge ref_clk_i);
			if (lv.size() == 0 || lv[$] !== level_o)
				lv.push_back(level_o);
			pulses += (pad_o[5] && !prev);
			prev = pad_o[5];
		end
	endtask
	task automatic ptrig();
		int m;
		m = 0;
		@(posedge ref_clk_i);
		ext_val[6] <= 1;
		repeat (6)
		begin
			@(negedge ref_clk_i);
			m += meas_trig_o;
		end
		@(posedge ref_clk_i);
		ext_val[6] <= 0;
		chk("meas trigger", m, 1);
	endtask

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial
	begin
		cyc(10);
		resetn_i <= 1;
		cyc(2);
		@(negedge ref_clk_i);
		chk("level points", level_points_o, 1);
		chk("dwell points", dwell_points_o, 1);
		kick(4);
		kick(0);
		kick(1);
		watch(3000);
		chk("dwell span", span inside {[995:1012]}, 1);
		chk("step level", lv[1], LEVEL_MIN);
		cyc(2);
		@(negedge ref_clk_i);
		chk("restored", level_o, 16'hC3C3);
		$display("test reset list done");
		@(posedge ref_clk_i);
		nv_pol_i <= 7'h55;
		nv_load_i <= 1;
		@(posedge ref_clk_i);
		nv_load_i <= 0;
		@(negedge ref_clk_i);
		chk("stored func", func_o[6], input_only_pin);
		chk("stored pol", pol_o, 7'h55);
		for (int i = 0; i < 7; i++)
			set_pin(i, ft[i], pin_pol_t'(i == 3));
		ext_en <= 7'h50;
		for (int k = 0; k < 8; k++)
		begin
			w = 7'(rnd());
			v = 7'(rnd());
			e = {v[6], 1'b0, v[4], w[3:0] ^ 4'h8};
			@(posedge ref_clk_i);
			ext_val <= v;
			out_wr_i <= 1;
			out_data_i <= w;
			@(posedge ref_clk_i);
			out_wr_i <= 0;
			@(negedge ref_clk_i);
			chk("readback", out_data_o, w);
			@(negedge ref_clk_i);
			chk("enables", pad_oe_o, 7'h2F);
			@(negedge ref_clk_i);
			chk("pins", in_data_o, e);
		end
		$display("test port data done");
		set_pin(0, fault_out_pin, active_high);
		set_pin(1, general_io_pin, active_high);
		@(negedge ref_clk_i);
		chk("common func", func_o[1], fault_out_pin);
		@(posedge ref_clk_i);
		protect_i <= 4'h4;
		cyc(3);
		@(negedge ref_clk_i);
		chk("fault out", pad_o[0] & pad_oe_o[0], 1);
		set_pin(0, general_io_pin, active_high);
		@(negedge ref_clk_i);
		chk("common left", func_o[1], input_only_pin);
		set_pin(1, general_io_pin, active_high);
		protect_i <= 4'h0;
		set_pin(3, inhibit_in_pin, active_low);
		set_pin(2, inhibit_in_pin, active_high);
		ext_en[2] <= 1;
		ext_val[2] <= 1;
		cyc(3);
		@(negedge ref_clk_i);
		chk("pin4 func", func_o[3], general_io_pin);
		chk("inhibit", outputs_inhibit_o, 1);
		set_pin(2, inhibit_in_pin, active_low);
		cyc(3);
		@(negedge ref_clk_i);
		chk("inhibit low", outputs_inhibit_o, 0);
		set_pin(2, general_io_pin, active_high);
		ext_en[2] <= 0;
		$display("test fault inhibit done");
		kick(3);
		ex = {16'hC3C3};
		for (int i = 0; i < 3; i++)
		begin
			r = rnd();
			lvl[i] = {r[13:0], 2'(i)};
			add_step(lvl[i], 18'(3 + i * 2), 2'(i == 2), i == 0, i == 1);
		end
		@(negedge ref_clk_i);
		chk("points", level_points_o, 3);
		chk("dwell pts", dwell_points_o, 3);
		for (int p = 0; p < 6; p++)
			ex.push_back(lvl[p % 3]);
		set_cfg(2, 0, 0, 1, 1);
		kick(0);
		kick(1);
		watch(500);
		chk("levels seen", lv.size(), 7);
		for (int i = 0; i < 7; i++)
			chk("list order", lv[i], ex[i]);
		chk("trig pulses", pulses, 4);
		// Each step takes its dwell units plus a load and an end cycle.
		chk("list span", span, 2 * (3 + 5 + 7 * 10 + 6) + 1);
		cyc(2);
		@(negedge ref_clk_i);
		chk("held level", level_o, lvl[2]);
		set_cfg(1, 0, 0, 0, 0);
		kick(0);
		kick(1);
		watch(500);
		chk("gated pulses", pulses, 0);
		$display("test auto list done");
		kick(3);
		add_step(16'hA5A0, 18'h0_0028, 2'h0, 0, 0);
		add_step(16'hA5A1, 18'h0_0028, 2'h0, 0, 0);
		set_cfg(1, 1, 1, 0, 0);
		trans_src_pin_i <= 1;
		meas_src_pin_i <= 1;
		// The trigger pin starts low so that the first pulse is a true edge.
		ext_val[6] <= 0;
		kick(0);
		ptrig();
		ptrig();
		cyc(50);
		@(negedge ref_clk_i);
		// The index already names the step that the next trigger loads.
		chk("held step", step_o, 1);
		chk("held value", level_o, 16'hA5A0);
		ptrig();
		@(negedge ref_clk_i);
		chk("next step", level_o, 16'hA5A1);
		kick(2);
		cyc(1);
		@(negedge ref_clk_i);
		chk("aborted", {list_active_o, level_o}, {1'b0, lvl[2]});
		$display("test single list done");
		give_verdict();
	end

	initial
	begin
		cyc(20000);
		mismatches++;
		give_verdict();
	end
endmodule

bind list_sequencer_digital_port list_seq_sva list_seq_sva_i (.*);

`default_nettype wire
